// ==== common/htc_defs.svh ====
// Register offsets, field positions, reset values and timing counts of the timer
`ifndef HTC_DEFS_SVH
`define HTC_DEFS_SVH
`define HTC_OFF_CTRL      4'h0
`define HTC_OFF_PRESCALE  4'h1
`define HTC_OFF_TOP       4'h2
`define HTC_OFF_COMPARE   4'h3
`define HTC_OFF_COUNT     4'h4
`define HTC_OFF_CAPTURE   4'h5
`define HTC_OFF_STATUS    4'h6
`define HTC_OFF_MASK      4'h7
`define HTC_CTRL_RUN      0
`define HTC_CTRL_MODE_LO  1
`define HTC_CTRL_MODE_HI  2
`define HTC_CTRL_CLKSEL   3
`define HTC_CTRL_CAPEN    4
`define HTC_CTRL_DOWN     5
`define HTC_CTRL_BUSEN    6
`define HTC_CTRL_WIDTH    7
`define HTC_ST_OVF        0
`define HTC_ST_CMP        1
`define HTC_ST_CAP        2
`define HTC_CTRL_RESET    7'h41
`define HTC_PRESC_RESET   16'h0000
`define HTC_TOP_RESET     16'hFFFF
`define HTC_CMP_RESET     16'h8000
`define HTC_CNT_ONES      16'hFFFF
`define HTC_CNT_ZERO      16'h0000
`define HTC_CNT_ONE       16'h0001
`endif

// ==== common/htc_pkg.sv ====
// Types shared by the timer modules
package htc_pkg;
	typedef enum logic [1:0] {
		HTC_MODE_WDOG = 2'h0,
		HTC_MODE_CTC  = 2'h1,
		HTC_MODE_FAST = 2'h2,
		HTC_MODE_PFC  = 2'h3
	} htc_mode_t;
	typedef enum logic [1:0] {
		HTC_BUS_IDLE = 2'h1,
		HTC_BUS_ACK  = 2'h2
	} htc_bus_st_t;
endpackage

// ==== common/htc_tick_if.sv ====
// Interface carrying prescaler control and tick between timer modules
interface htc_tick_if;
	logic        srcSel;
	logic        extClk;
	logic        run;
	logic [15:0] divide;
	logic        tick;
	modport core (output srcSel, output extClk, output run, output divide, input tick);
	modport presc (input srcSel, input extClk, input run, input divide, output tick);
endinterface

// ==== logic/htc_prescaler.sv ====
// Clock source select and prescaler producing one-cycle count ticks
`include "htc_defs.svh"
module htc_prescaler
	import htc_pkg::*;
(
	input  wire logic mclk,
	input  wire logic nrst,
	htc_tick_if.presc tk
);
	typedef struct packed {
		logic [15:0] div;
		logic        extQ;
		logic        tick;
	} htc_presc_state_t;
	htc_presc_state_t s_q, s_d;
	// Source edge, then divide by divide+1
	always_comb begin
		logic srcEv;
		srcEv = 1'b0;
		s_d = s_q;
		s_d.extQ = tk.extClk;
		s_d.tick = 1'b0;
		srcEv = tk.srcSel ? (tk.extClk & ~s_q.extQ) : 1'b1;
		if (!tk.run) begin
			s_d.div = `HTC_CNT_ZERO;
		end else if (srcEv) begin
			if (s_q.div >= tk.divide) begin
				s_d.div = `HTC_CNT_ZERO;
				s_d.tick = 1'b1;
			end else begin
				s_d.div = s_q.div + `HTC_CNT_ONE;
			end
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign tk.tick = s_q.tick;
	tickGap_a: assert property (@(posedge mclk) disable iff (!nrst)
		tk.tick && tk.divide != 16'h0000 |=> !tk.tick) else $error("tick too dense");
endmodule

// ==== logic/htc_timer.sv ====
// 16-bit timer/counter with compare, capture, PWM and Avalon-MM registers
// Operation
// - 16-bit up/down counter with compare unit
// - Watchdog, clear-on-compare, fast and correct PWM
// - Selectable clock source and programmable prescaler
// - Overflow, compare and capture interrupt sources
// - One interrupt output and one wake-up output
// - Glitch-free PWM, variable period, auto reload
// - Synchronised rising capture edge stores count in bus mode outside PWM
// - Stand-alone irq is overflow; else masked
// - Active-low counter reset pin always honoured
// - Stand-alone mode uses control values written over the bus
// - Bus master reads and writes the registers
// - Waveform drives dedicated timer output
`include "htc_defs.svh"
module htc_timer
	import htc_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        counterClockIn,
	input  wire logic        counterResetN,
	input  wire logic        captureTriggerIn,
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	output logic             counterIrqOut,
	output logic             wakeIrqOut,
	output logic             waveformOut
);
	typedef struct packed {
		logic [`HTC_CTRL_WIDTH-1:0] ctrl;
		logic [15:0] presc;
		logic [15:0] top;
		logic [15:0] cmp;
		logic [15:0] cmpAct;
		logic [15:0] topAct;
		logic [15:0] count;
		logic [15:0] capture;
		logic [2:0]  status;
		logic [2:0]  mask;
		logic        dirDown;
		logic        capS1;
		logic        capS2;
		logic        capS3;
		logic        rstS1;
		logic        rstS2;
		logic        wave;
		logic        irq;
		logic        wake;
		logic [31:0] rdata;
		htc_bus_st_t bus;
	} htc_state_t;
	htc_state_t s_q, s_d;
	htc_tick_if tk();
	htc_prescaler u_presc (
		.mclk (mclk),
		.nrst (nrst),
		.tk   (tk)
	);
	// Merge a 32-bit write into a 16-bit field by byte lanes
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [15:0] r;
		r = old;
		if (be[0]) r[7:0] = wd[7:0];
		if (be[1]) r[15:8] = wd[15:8];
		return r;
	endfunction
	wire htc_mode_t mode = htc_mode_t'(s_q.ctrl[`HTC_CTRL_MODE_HI:`HTC_CTRL_MODE_LO]);
	wire logic busEn = s_q.ctrl[`HTC_CTRL_BUSEN];
	wire logic isPwm = (mode == HTC_MODE_FAST) || (mode == HTC_MODE_PFC);
	assign tk.srcSel = s_q.ctrl[`HTC_CTRL_CLKSEL];
	assign tk.extClk = counterClockIn;
	assign tk.run    = s_q.ctrl[`HTC_CTRL_RUN] & s_q.rstS2;
	assign tk.divide = s_q.presc;
	// Next-state logic: bus slave, counter, capture, interrupts
	always_comb begin
		logic        ovfEv;
		logic        cmpEv;
		logic        capEv;
		logic        acc;
		logic [15:0] lim;
		logic [2:0]  clr;
		ovfEv = 1'b0;
		cmpEv = 1'b0;
		capEv = 1'b0;
		acc = 1'b0;
		lim = `HTC_CNT_ZERO;
		clr = 3'h0;
		s_d = s_q;
		// Two-stage synchronisers for reset pin and capture input
		s_d.rstS1 = counterResetN;
		s_d.rstS2 = s_q.rstS1;
		s_d.capS1 = captureTriggerIn;
		s_d.capS2 = s_q.capS1;
		s_d.capS3 = s_q.capS2;
		// Avalon slave: one wait cycle, then answer
		acc = (read | write) && s_q.bus == HTC_BUS_IDLE;
		s_d.bus = acc ? HTC_BUS_ACK : HTC_BUS_IDLE;
		if (acc && read) begin
			case (address)
				`HTC_OFF_CTRL:     s_d.rdata = {25'h0, s_q.ctrl};
				`HTC_OFF_PRESCALE: s_d.rdata = {16'h0, s_q.presc};
				`HTC_OFF_TOP:      s_d.rdata = {16'h0, s_q.top};
				`HTC_OFF_COMPARE:  s_d.rdata = {16'h0, s_q.cmp};
				`HTC_OFF_COUNT:    s_d.rdata = {16'h0, s_q.count};
				`HTC_OFF_CAPTURE:  s_d.rdata = {16'h0, s_q.capture};
				`HTC_OFF_STATUS:   s_d.rdata = {29'h0, s_q.status};
				`HTC_OFF_MASK:     s_d.rdata = {29'h0, s_q.mask};
				default:           s_d.rdata = 32'h0;
			endcase
		end
		if (acc && write) begin
			case (address)
				`HTC_OFF_CTRL: begin
					if (byteenable[0]) s_d.ctrl = writedata[`HTC_CTRL_WIDTH-1:0];
				end
				`HTC_OFF_PRESCALE: s_d.presc = merge16(s_q.presc, writedata, byteenable);
				`HTC_OFF_TOP:      s_d.top = merge16(s_q.top, writedata, byteenable);
				`HTC_OFF_COMPARE:  s_d.cmp = merge16(s_q.cmp, writedata, byteenable);
				`HTC_OFF_STATUS: begin
					if (byteenable[0]) clr = writedata[2:0];
				end
				`HTC_OFF_MASK: begin
					if (byteenable[0]) s_d.mask = writedata[2:0];
				end
				default: ;
			endcase
		end
		// Counter step on each prescaled tick
		lim = (mode == HTC_MODE_WDOG) ? `HTC_CNT_ONES : s_q.topAct;
		if (!s_q.rstS2) begin
			s_d.count = `HTC_CNT_ZERO;
			s_d.dirDown = 1'b0;
		end else if (tk.tick) begin
			case (mode)
				HTC_MODE_PFC: begin
					// Up to top then down to zero, reload at bottom
					if (!s_q.dirDown) begin
						if (s_q.count >= lim) begin
							s_d.dirDown = 1'b1;
							s_d.count = s_q.count - `HTC_CNT_ONE;
						end else begin
							s_d.count = s_q.count + `HTC_CNT_ONE;
						end
					end else if (s_q.count == `HTC_CNT_ZERO) begin
						s_d.dirDown = 1'b0;
						s_d.count = `HTC_CNT_ONE;
						s_d.topAct = s_q.top;
						s_d.cmpAct = s_q.cmp;
						ovfEv = 1'b1;
					end else begin
						s_d.count = s_q.count - `HTC_CNT_ONE;
					end
				end
				default: begin
					if (s_q.ctrl[`HTC_CTRL_DOWN] && mode == HTC_MODE_WDOG) begin
						// Watchdog down-count expires at zero
						s_d.count = s_q.count - `HTC_CNT_ONE;
						ovfEv = (s_q.count == `HTC_CNT_ZERO);
					end else if (s_q.count >= lim) begin
						s_d.count = `HTC_CNT_ZERO;
						ovfEv = 1'b1;
						s_d.topAct = s_q.top;
						s_d.cmpAct = s_q.cmp;
					end else begin
						s_d.count = s_q.count + `HTC_CNT_ONE;
					end
				end
			endcase
			cmpEv = (s_q.count == s_q.cmpAct);
		end
		if (mode != HTC_MODE_PFC) begin
			s_d.dirDown = 1'b0;
		end
		// Waveform: toggle in non-PWM, set/clear on compare in PWM
		if (isPwm) begin
			s_d.wave = (s_d.count < s_q.cmpAct);
		end else if (cmpEv) begin
			s_d.wave = ~s_q.wave;
		end
		// Capture rising edge of synchronised trigger
		capEv = busEn && !isPwm && s_q.ctrl[`HTC_CTRL_CAPEN] && s_q.capS2 && !s_q.capS3;
		if (capEv) begin
			s_d.capture = s_q.count;
		end
		// Sticky status, set wins over write-one clear
		s_d.status = (s_q.status & ~clr) | {capEv, cmpEv, ovfEv};
		s_d.irq = busEn ? |(s_d.status & s_d.mask) : s_d.status[`HTC_ST_OVF];
		s_d.wake = ovfEv | (cmpEv & s_q.mask[`HTC_ST_CMP]);
	end
	// State register; reset loads control 0x41: running watchdog with bus enabled
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			s_q         <= '0;
			s_q.ctrl    <= `HTC_CTRL_RESET;
			s_q.presc   <= `HTC_PRESC_RESET;
			s_q.top     <= `HTC_TOP_RESET;
			s_q.topAct  <= `HTC_TOP_RESET;
			s_q.cmp     <= `HTC_CMP_RESET;
			s_q.cmpAct  <= `HTC_CMP_RESET;
			s_q.bus     <= HTC_BUS_IDLE;
		end else begin
			s_q <= s_d;
		end
	end
	// Outputs straight from flip-flops, except waitrequest, decoded from read and write with the registered bus state
	assign readdata      = s_q.rdata;
	assign waitrequest   = (read | write) && s_q.bus != HTC_BUS_ACK;
	assign counterIrqOut = s_q.irq;
	assign wakeIrqOut    = s_q.wake;
	assign waveformOut   = s_q.wave;
	// Checks
	wrapZero_a: assert property (@(posedge mclk) disable iff (!nrst)
		tk.tick && s_q.rstS2 && mode == HTC_MODE_CTC && s_q.count >= s_q.topAct
		|=> s_q.count == 16'h0000 && s_q.status[0]) else $error("no wrap");
	ovfFlag_a: assert property (@(posedge mclk) disable iff (!nrst)
		$past(!busEn) |-> counterIrqOut == s_q.status[`HTC_ST_OVF])
		else $error("irq not overflow");
	irqMask_a: assert property (@(posedge mclk) disable iff (!nrst)
		$past(busEn) |-> counterIrqOut == |(s_q.status & s_q.mask))
		else $error("irq not masked status");
	capStore_a: assert property (@(posedge mclk) disable iff (!nrst)
		s_q.capS2 && !s_q.capS3 && busEn && !isPwm && s_q.ctrl[`HTC_CTRL_CAPEN]
		|=> s_q.capture == $past(s_q.count) && s_q.status[2]) else $error("capture lost");
	pinReset_a: assert property (@(posedge mclk) disable iff (!nrst)
		!counterResetN ##2 1'b1 |=> s_q.count == 16'h0000) else $error("reset pin ignored");
	busAns_a: assert property (@(posedge mclk) disable iff (!nrst)
		(read | write) && waitrequest |=> !waitrequest) else $error("slow answer");
	pwmWave_a: assert property (@(posedge mclk) disable iff (!nrst)
		mode == HTC_MODE_FAST && $stable(mode) |=> waveformOut == ($past(s_d.count) < $past(s_q.cmpAct)))
		else $error("pwm level");
	cmpSet_a: assert property (@(posedge mclk) disable iff (!nrst)
		tk.tick && s_q.rstS2 && s_q.count == s_q.cmpAct |=> s_q.status[1]) else $error("no compare");
	wakeOvf_a: assert property (@(posedge mclk) disable iff (!nrst)
		$rose(s_q.status[0]) |-> wakeIrqOut) else $error("no wake");
	pfcDown_a: assert property (@(posedge mclk) disable iff (!nrst)
		mode == HTC_MODE_PFC && s_q.dirDown && tk.tick && s_q.count != 16'h0000 && s_q.rstS2
		|=> s_q.count == $past(s_q.count) - 16'h0001) else $error("no down count");
	ovfCov_c: cover property (@(posedge mclk) disable iff (!nrst) s_q.status[0]);
	capCov_c: cover property (@(posedge mclk) disable iff (!nrst) s_q.status[2]);
	pfcCov_c: cover property (@(posedge mclk) disable iff (!nrst) mode == HTC_MODE_PFC && s_q.dirDown);
endmodule

// ==== tb/htc_avm_master.sv ====
// Avalon-MM master model standing for the fabric user logic
module htc_avm_master (
	input  wire logic        mclk,
	output logic      [3:0]  address,
	output logic             read,
	output logic             write,
	output logic      [31:0] writedata,
	output logic      [3:0]  byteenable,
	input  wire logic [31:0] readdata,
	input  wire logic        waitrequest,
	output logic             busHang
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h00000000;
		byteenable = 4'h0;
		busHang = 1'b0;
	end
	// One transfer, held until waitrequest is sampled low
	task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge mclk);
		address <= a;
		read <= !w;
		write <= w;
		writedata <= d;
		byteenable <= 4'h3;
		@(posedge mclk);
		while (waitrequest !== 1'b0 && n < 20) begin
			@(posedge mclk);
			n++;
		end
		q = readdata;
		if (n >= 20) busHang <= 1'b1;
		read <= 1'b0;
		write <= 1'b0;
	endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the hardened timer/counter
`include "htc_defs.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, nrst, counterClockIn, counterResetN, captureTriggerIn;
	logic [3:0]  address, byteenable;
	logic        read, write, waitrequest, busHang, wakeSeen;
	logic        counterIrqOut, wakeIrqOut, waveformOut;
	logic [31:0] writedata, readdata, q, c;
	int          err_count, samples_checked, hi, rises;
	htc_timer uut (.*);
	htc_avm_master bus (.*);
	// Clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// External count source and wake pulse monitor
	always @(posedge mclk) begin
		counterClockIn <= ~counterClockIn;
		if (wakeIrqOut === 1'b1) wakeSeen <= 1'b1;
	end
	// A stuck bus ends the run
	always @(posedge busHang) begin
		err_count++;
		wrap_up();
	end
	task automatic wrap_up();
		if (err_count == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		bus.xfer(a, 1'b0, 32'h00000000, d);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus.xfer(a, 1'b1, d, x);
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// Bounded wait for the interrupt level
	task automatic wait_irq(input int lim);
		int n;
		n = 0;
		while (counterIrqOut !== 1'b1 && n < lim) begin
			@(posedge mclk);
			n++;
		end
		if (n >= lim) begin
			err_count++;
			$display("BAD %0t: interrupt missing", $time);
			wrap_up();
		end
	endtask
	// High cycles and rising edges of the waveform over a window
	task automatic measure(input int win);
		logic p;
		hi = 0;
		rises = 0;
		p = waveformOut;
		repeat (win) begin
			@(posedge mclk);
			if (waveformOut === 1'b1) hi++;
			if (waveformOut === 1'b1 && p === 1'b0) rises++;
			p = waveformOut;
		end
	endtask
	task automatic pulse();
		captureTriggerIn <= 1'b1;
		step(6);
		captureTriggerIn <= 1'b0;
		step(2);
	endtask
	task automatic t_reset();
		rd(`HTC_OFF_CTRL, q);
		cmp(q, 32'h00000041);
		rd(`HTC_OFF_PRESCALE, q);
		cmp(q, 32'h00000000);
		rd(`HTC_OFF_TOP, q);
		cmp(q, 32'h0000FFFF);
		rd(`HTC_OFF_COMPARE, q);
		cmp(q, 32'h00008000);
		wr(4'hA, 32'h0000FFFF);
		rd(4'hA, q);
		cmp(q, 32'h00000000);
		wr(`HTC_OFF_TOP, 32'h0000001F);
		wr(`HTC_OFF_COMPARE, 32'h00000010);
	endtask
	task automatic t_overflow();
		wr(`HTC_OFF_MASK, 32'h00000001);
		wait_irq(70000);
		rd(`HTC_OFF_STATUS, q);
		cmp(q & 32'h00000001, 32'h00000001);
		rd(`HTC_OFF_COUNT, q);
		cmp(32'(q < 32'h00000040), 32'h00000001);
		cmp({31'h0, wakeSeen}, 32'h00000001);
		wr(`HTC_OFF_MASK, 32'h00000000);
		step(2);
		cmp({31'h0, counterIrqOut}, 32'h00000000);
		wr(`HTC_OFF_STATUS, 32'h00000001);
		rd(`HTC_OFF_STATUS, q);
		cmp(q & 32'h00000001, 32'h00000000);
	endtask
	task automatic t_ctc();
		counterResetN <= 1'b0;
		step(5);
		rd(`HTC_OFF_COUNT, q);
		cmp(q, 32'h00000000);
		wr(`HTC_OFF_CTRL, 32'h00000043);
		wr(`HTC_OFF_STATUS, 32'h00000007);
		wr(`HTC_OFF_MASK, 32'h00000002);
		counterResetN <= 1'b1;
		wait_irq(100);
		rd(`HTC_OFF_STATUS, q);
		cmp(q & 32'h00000002, 32'h00000002);
		measure(68);
		cmp(32'(rises >= 1 && rises <= 3), 32'h00000001);
		// Stand-alone: irq follows the overflow flag despite an empty mask
		wr(`HTC_OFF_MASK, 32'h00000000);
		wr(`HTC_OFF_STATUS, 32'h00000007);
		wr(`HTC_OFF_CTRL, 32'h00000003);
		wait_irq(100);
		rd(`HTC_OFF_STATUS, q);
		cmp(q & 32'h00000001, 32'h00000001);
	endtask
	task automatic t_capture();
		wr(`HTC_OFF_MASK, 32'h00000000);
		wr(`HTC_OFF_STATUS, 32'h00000007);
		wr(`HTC_OFF_CTRL, 32'h00000042);
		pulse();
		rd(`HTC_OFF_STATUS, q);
		cmp(q & 32'h00000004, 32'h00000000);
		wr(`HTC_OFF_CTRL, 32'h00000052);
		rd(`HTC_OFF_COUNT, c);
		pulse();
		rd(`HTC_OFF_CAPTURE, q);
		cmp(q, c);
		rd(`HTC_OFF_STATUS, q);
		cmp(q & 32'h00000004, 32'h00000004);
	endtask
	// Fast and correct PWM, prescaled and external source
	task automatic t_pwm();
		logic [31:0] pr [4] = '{32'h00000000, 32'h00000000, 32'h00000001, 32'h00000000};
		logic [31:0] ct [4] = '{32'h00000045, 32'h00000047, 32'h00000045, 32'h0000004D};
		int          wn [4] = '{128, 124, 256, 256};
		for (int i = 0; i < 4; i++) begin
			wr(`HTC_OFF_PRESCALE, pr[i]);
			wr(`HTC_OFF_CTRL, ct[i]);
			step(140);
			measure(wn[i]);
			cmp(32'(hi >= wn[i] / 2 - 4 && hi <= wn[i] / 2 + 4), 32'h00000001);
			cmp(32'(rises >= 1 && rises <= 5), 32'h00000001);
		end
	endtask
	// Main sequence
	initial begin
		nrst = 1'b0;
		counterClockIn = 1'b0;
		counterResetN = 1'b1;
		captureTriggerIn = 1'b0;
		wakeSeen = 1'b0;
		err_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		t_reset();
		t_overflow();
		t_ctc();
		t_capture();
		t_pwm();
		wrap_up();
	end
endmodule
